/* include/fifo_host_pkg.sv */
package fifo_host_pkg;

	// width of one buffered word and number of cells in the device
	localparam int WORD_W = 5;
	localparam int DEPTH = 16;

	// local clock period and synchroniser length
	localparam int CLK_NS = 40;
	localparam int SYNC_CYC = 2;

	// device timing, in nanoseconds as printed
	localparam int CLR_LOW_NS = 40;
	localparam int CLR_SETUP_NS = 25;
	localparam int LOAD_HIGH_NS = 25;
	localparam int DATA_HOLD_NS = 70;
	localparam int LOAD_TO_IR_NS = 75;
	localparam int UNLOAD_LOW_NS = 7;
	localparam int UNLOAD_TO_OR_NS = 45;
	localparam int FALL_NS = 300;

	// a least time rounded up to whole cycles, never below one
	function automatic int cyc_up(input int ns);
		int c;
		c = (ns + CLK_NS - 1) / CLK_NS;
		return (c < 1) ? 1 : c;
	endfunction

	function automatic int max_int(input int a, input int b);
		return (a > b) ? a : b;
	endfunction

	localparam int CNT_W = 4;
	localparam logic [CNT_W-1:0] CNT_ONE = 4'h1;
	localparam logic [CNT_W-1:0] CLR_CYC = CNT_W'(cyc_up(CLR_LOW_NS));
	localparam logic [CNT_W-1:0] SETUP_CYC = CNT_W'(cyc_up(CLR_SETUP_NS));
	localparam logic [CNT_W-1:0] LOAD_CYC = CNT_W'(cyc_up(LOAD_HIGH_NS));
	// after a load the flag must be seen through the synchroniser before trusting it
	localparam logic [CNT_W-1:0] LOAD_GUARD_CYC =
		CNT_W'(max_int(cyc_up(DATA_HOLD_NS), cyc_up(LOAD_TO_IR_NS) + SYNC_CYC));
	localparam logic [CNT_W-1:0] UNL_CYC = CNT_W'(cyc_up(UNLOAD_LOW_NS));
	localparam logic [CNT_W-1:0] OR_GUARD_CYC = CNT_W'(cyc_up(UNLOAD_TO_OR_NS) + SYNC_CYC);
	localparam logic [CNT_W-1:0] FALL_CYC = CNT_W'(cyc_up(FALL_NS));

	// pins that the controller drives into the buffer
	typedef struct packed {
		logic buffer_clear_n;
		logic load_strobe_a;
		logic load_strobe_b;
		logic unload_strobe_in;
		logic output_enable_n;
		logic [WORD_W-1:0] write_word_in;
	} fifo_drive_s;

	// pins that the buffer drives back
	typedef struct packed {
		logic space_avail_flag;
		logic output_ready;
		logic [WORD_W-1:0] read_word_out;
	} fifo_sense_s;

	typedef enum logic [2:0] {
		W_RST = 3'b000,
		W_CLR = 3'b001,
		W_REC = 3'b010,
		W_IDLE = 3'b011,
		W_LOAD = 3'b100,
		W_HOLD = 3'b101
	} wr_state_e;

	typedef enum logic [2:0] {
		R_IDLE = 3'b000,
		R_SETTLE = 3'b001,
		R_HAVE = 3'b010,
		R_UNL = 3'b011,
		R_GUARD = 3'b100
	} rd_state_e;

endpackage

/* rtl/fifo_host_ctrl.sv */
`timescale 1ns/1ps

// Operation
// - pulse clear low after reset, before use
// - never load while space flag is low
// - unload only with output ready high
// - flag low for fall-through time means full/empty
// - cascade: unload pulse drives next load strobe
module fifo_host_ctrl (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic ce,
	input wire logic wr_valid,
	output logic wr_ready,
	input wire logic [fifo_host_pkg::WORD_W-1:0] wr_word,
	output logic rd_valid,
	input wire logic rd_ready,
	output logic [fifo_host_pkg::WORD_W-1:0] rd_word,
	output logic buffer_full,
	output logic buffer_empty,
	output fifo_host_pkg::fifo_drive_s fifo_pins,
	input wire fifo_host_pkg::fifo_sense_s fifo_sense
);
	import fifo_host_pkg::*;

	// two-stage synchroniser for every pin the buffer drives
	fifo_sense_s sync1_reg, sync2_reg;
	logic ir_sync, or_sync;

	// write side state
	wr_state_e w_state_reg, w_state_next;
	logic [CNT_W-1:0] w_cnt_reg, w_cnt_next;
	logic clear_n_reg, clear_n_next;
	logic load_reg, load_next;
	logic oe_n_reg, oe_n_next;
	logic [WORD_W-1:0] word_out_reg, word_out_next;

	// read side state
	rd_state_e r_state_reg, r_state_next;
	logic [CNT_W-1:0] r_cnt_reg, r_cnt_next;
	logic unl_reg, unl_next;
	logic [WORD_W-1:0] rd_word_reg, rd_word_next;

	// full and empty qualification counters
	logic [CNT_W-1:0] full_cnt_reg, full_cnt_next;
	logic [CNT_W-1:0] empty_cnt_reg, empty_cnt_next;
	// helper for checking: set once the first clear pulse has been given
	logic cleared_reg, cleared_next;

	// the first stage feeds only the second; logic reads the second
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			sync1_reg <= '0;
			sync2_reg <= '0;
		end else if (ce) begin
			sync1_reg <= fifo_sense;
			sync2_reg <= sync1_reg;
		end
	end

	assign ir_sync = sync2_reg.space_avail_flag;
	assign or_sync = sync2_reg.output_ready;

	// write side: clear sequence, then one load per free slot
	always_comb begin
		w_state_next = w_state_reg;
		w_cnt_next = w_cnt_reg;
		clear_n_next = clear_n_reg;
		load_next = load_reg;
		oe_n_next = oe_n_reg;
		word_out_next = word_out_reg;
		cleared_next = cleared_reg;
		unique case (w_state_reg)
			W_RST: begin
				clear_n_next = 1'b0;
				w_cnt_next = CLR_CYC;
				w_state_next = W_CLR;
			end
			W_CLR: begin
				// hold clear low for its least width
				if (w_cnt_reg == CNT_ONE) begin
					clear_n_next = 1'b1;
					cleared_next = 1'b1;
					w_cnt_next = SETUP_CYC;
					w_state_next = W_REC;
				end else begin
					w_cnt_next = w_cnt_reg - CNT_ONE;
				end
			end
			W_REC: begin
				// clear release must precede the first load strobe
				if (w_cnt_reg == CNT_ONE) begin
					oe_n_next = 1'b0;
					w_state_next = W_IDLE;
				end else begin
					w_cnt_next = w_cnt_reg - CNT_ONE;
				end
			end
			W_IDLE: begin
				// load only on a seen-high space flag
				if (wr_valid && ir_sync) begin
					word_out_next = wr_word;
					load_next = 1'b1;
					w_cnt_next = LOAD_CYC;
					w_state_next = W_LOAD;
				end
			end
			W_LOAD: begin
				// both strobes high together for their least width
				if (w_cnt_reg == CNT_ONE) begin
					load_next = 1'b0;
					w_cnt_next = LOAD_GUARD_CYC;
					w_state_next = W_HOLD;
				end else begin
					w_cnt_next = w_cnt_reg - CNT_ONE;
				end
			end
			W_HOLD: begin
				// word stays on the pins; the stale high flag must drain from the sync
				if (w_cnt_reg == CNT_ONE) begin
					w_state_next = W_IDLE;
				end else begin
					w_cnt_next = w_cnt_reg - CNT_ONE;
				end
			end
			default: begin
				w_state_next = W_RST;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			w_state_reg <= W_RST;
			w_cnt_reg <= '0;
			clear_n_reg <= 1'b1;
			load_reg <= 1'b0;
			oe_n_reg <= 1'b1;
			word_out_reg <= '0;
			cleared_reg <= 1'b0;
		end else if (ce) begin
			w_state_reg <= w_state_next;
			w_cnt_reg <= w_cnt_next;
			clear_n_reg <= clear_n_next;
			load_reg <= load_next;
			oe_n_reg <= oe_n_next;
			word_out_reg <= word_out_next;
			cleared_reg <= cleared_next;
		end
	end

	assign wr_ready = (w_state_reg == W_IDLE) && ir_sync && ce;
	// read side: take word shown by output ready, then unload it
	always_comb begin
		r_state_next = r_state_reg;
		r_cnt_next = r_cnt_reg;
		unl_next = unl_reg;
		rd_word_next = rd_word_reg;
		unique case (r_state_reg)
			R_IDLE: begin
				// only after the clear sequence has finished
				if (or_sync && !oe_n_reg) begin
					r_state_next = R_SETTLE;
				end
			end
			R_SETTLE: begin
				// one extra cycle covers data trailing the ready flag
				rd_word_next = sync2_reg.read_word_out;
				r_state_next = R_HAVE;
			end
			R_HAVE: begin
				// unload strobe low only with a word present
				if (rd_ready) begin
					unl_next = 1'b0;
					r_cnt_next = UNL_CYC;
					r_state_next = R_UNL;
				end
			end
			R_UNL: begin
				if (r_cnt_reg == CNT_ONE) begin
					unl_next = 1'b1;
					r_cnt_next = OR_GUARD_CYC;
					r_state_next = R_GUARD;
				end else begin
					r_cnt_next = r_cnt_reg - CNT_ONE;
				end
			end
			R_GUARD: begin
				// wait until the old high ready has left the synchroniser
				if (r_cnt_reg == CNT_ONE) begin
					r_state_next = R_IDLE;
				end else begin
					r_cnt_next = r_cnt_reg - CNT_ONE;
				end
			end
			default: begin
				r_state_next = R_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			r_state_reg <= R_IDLE;
			r_cnt_reg <= '0;
			unl_reg <= 1'b1;
			rd_word_reg <= '0;
		end else if (ce) begin
			r_state_reg <= r_state_next;
			r_cnt_reg <= r_cnt_next;
			unl_reg <= unl_next;
			rd_word_reg <= rd_word_next;
		end
	end

	assign rd_valid = (r_state_reg == R_HAVE);
	assign rd_word = rd_word_reg;
	// status: a flag low for the whole fall-through time means full or empty
	always_comb begin
		full_cnt_next = full_cnt_reg;
		empty_cnt_next = empty_cnt_reg;
		if (ir_sync) begin
			full_cnt_next = '0;
		end else if (full_cnt_reg != FALL_CYC) begin
			full_cnt_next = full_cnt_reg + CNT_ONE;
		end
		if (or_sync) begin
			empty_cnt_next = '0;
		end else if (empty_cnt_reg != FALL_CYC) begin
			empty_cnt_next = empty_cnt_reg + CNT_ONE;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			full_cnt_reg <= '0;
			empty_cnt_reg <= '0;
		end else if (ce) begin
			full_cnt_reg <= full_cnt_next;
			empty_cnt_reg <= empty_cnt_next;
		end
	end

	// a clear drops output ready and raises the space flag, so neither status is trusted before setup ends
	assign buffer_full = (full_cnt_reg == FALL_CYC) && !oe_n_reg;
	assign buffer_empty = (empty_cnt_reg == FALL_CYC) && !oe_n_reg;
	// both load strobes from one register suit cascaded wiring too
	assign fifo_pins = '{
		buffer_clear_n: clear_n_reg,
		load_strobe_a: load_reg,
		load_strobe_b: load_reg,
		unload_strobe_in: unl_reg,
		output_enable_n: oe_n_reg,
		write_word_in: word_out_reg
	};
	// checks
	sequence ir_low_run;
		(!ir_sync && ce)[*8];
	endsequence
	sequence or_low_run;
		(!or_sync && ce)[*8];
	endsequence
	clear_after_reset_a: assert property (
		@(posedge clk) disable iff (sys_rst) (w_state_reg == W_RST && ce) |=> !clear_n_reg)
		else $error("clear not driven low after reset");
	load_after_clear_a: assert property (
		@(posedge clk) disable iff (sys_rst) load_reg |-> cleared_reg && clear_n_reg)
		else $error("load strobe before clear pulse");
	load_needs_space_a: assert property (
		@(posedge clk) disable iff (sys_rst) $rose(load_reg) |-> $past(ir_sync))
		else $error("load strobe while space flag low");
	full_status_a: assert property (
		@(posedge clk) disable iff (sys_rst) (ir_low_run ##0 !oe_n_reg) |=> buffer_full)
		else $error("full not shown after long low space flag");
	empty_status_a: assert property (
		@(posedge clk) disable iff (sys_rst) (or_low_run ##0 !oe_n_reg) |=> buffer_empty)
		else $error("empty not shown after long low ready flag");
	unload_needs_word_a: assert property (
		@(posedge clk) disable iff (sys_rst) $fell(unl_reg) |-> $past(rd_valid && rd_ready))
		else $error("unload strobe without held word");
endmodule

/* dv/fifo_dev_model.sv */
`timescale 1ns/1ps

// behavioural sixteen-word buffer seen through its pins
module fifo_dev_model
	import fifo_host_pkg::*;
(
	input wire fifo_host_pkg::fifo_drive_s pins,
	output fifo_host_pkg::fifo_sense_s sense
);
	logic [WORD_W-1:0] q[$]; // cells, front is the output stage
	logic [WORD_W-1:0] head; // word shown on the outputs
	logic ir, ordy, unl; // space flag, output ready, unload in progress
	logic unload_pulse_out; // cascade strobe, idles high
	initial begin
		ir = 0;
		ordy = 0;
		unl = 0;
		head = '0;
		unload_pulse_out = 1;
	end
	always @(negedge pins.buffer_clear_n) begin
		q.delete();
		ordy = 0;
		#20 ir = 1;
	end
	always @(posedge (pins.load_strobe_a & pins.load_strobe_b)) begin
		if (ir && pins.buffer_clear_n) begin
			#1 q.push_back(pins.write_word_in);
			ir = 0;
			// first cell releases its word downstream
			unload_pulse_out = 0;
			#15 unload_pulse_out = 1;
			#45 ir = (q.size() < DEPTH);
		end
	end
	always begin
		wait (q.size() > 0 && !ordy && !unl);
		#300;
		if (q.size() > 0 && !ordy && !unl) begin
			head = q[0];
			ordy = 1;
		end
	end
	always @(negedge pins.unload_strobe_in) begin
		if (ordy) begin
			unl = 1;
			#30 ordy = 0;
		end
	end
	always @(posedge pins.unload_strobe_in) begin
		if (unl) begin
			void'(q.pop_front());
			unl = 0;
			// a freed cell bubbles back to the input slowly
			if (!ir) fork #250 ir = 1; join_none
			if (q.size() > 0) begin
				#45 head = q[0];
				ordy = 1;
			end
		end
	end
	// word outputs only while enabled; a disabled bus shows the inverse, never the old word
	assign sense = '{
		space_avail_flag: ir,
		output_ready: ordy,
		read_word_out: pins.output_enable_n ? ~head : head
	};
endmodule

/* dv/tb_top.sv */
`timescale 1ns/1ps
`define CHK(n, e, a) begin num_checks++; if ((a) !== (e)) begin err_count++; \
	$display("Error %s expected %0h seen %0h", n, e, a); end end

module tb_top;
	import fifo_host_pkg::*;
	logic clk, sys_rst, ce, wr_valid, rd_ready, wr_ready, rd_valid, buffer_full, buffer_empty;
	logic [WORD_W-1:0] wr_word, rd_word, exp_w, last_word;
	fifo_drive_s fifo_pins;
	fifo_sense_s fifo_sense;
	int err_count, num_checks, cyc, seed;
	logic [WORD_W-1:0] sb[$]; // words written, not yet read
	logic rd_on; // sink allowed to accept

	fifo_host_ctrl dut_u (.clk(clk), .sys_rst(sys_rst), .ce(ce), .wr_valid(wr_valid),
		.wr_ready(wr_ready), .wr_word(wr_word), .rd_valid(rd_valid), .rd_ready(rd_ready),
		.rd_word(rd_word), .buffer_full(buffer_full), .buffer_empty(buffer_empty),
		.fifo_pins(fifo_pins), .fifo_sense(fifo_sense));
	fifo_dev_model dev_u (.pins(fifo_pins), .sense(fifo_sense));

	always #20 clk = ~clk;

	// hang guard
	always @(posedge clk) begin
		cyc++;
		if (cyc == 60000) begin
			err_count++;
			print_verdict();
		end
	end

	// a load must only start while the device has room
	always @(posedge fifo_pins.load_strobe_a) `CHK("load_room", 1'b1, fifo_sense.space_avail_flag)

	// sink with random stalls, order checked against the scoreboard
	always @(posedge clk) begin
		if (!sys_rst && rd_valid === 1'b1 && rd_ready === 1'b1 && sb.size() > 0) begin
			exp_w = sb.pop_front();
			`CHK("rd_word", exp_w, rd_word)
			last_word = exp_w;
		end
		#1 rd_ready = rd_on && ($random(seed) % 3 != 0);
	end

	task automatic put(input logic [WORD_W-1:0] w);
		int n;
		n = 0;
		wr_word = w;
		wr_valid = 1;
		// ready only moves on rising edges, so the falling edge sees it settled
		@(negedge clk);
		while (wr_ready !== 1'b1 && n < 400) begin
			@(negedge clk);
			n++;
		end
		// a write that is never accepted is a failure, not a silent skip
		if (wr_ready !== 1'b1) err_count++;
		@(posedge clk);
		sb.push_back(w);
		#1 wr_valid = 0;
		// let one edge pass so the next call never drives valid twice in one step
		@(posedge clk);
		#1;
	endtask

	task automatic drain();
		int n;
		n = 0;
		rd_on = 1;
		while (sb.size() > 0 && n < 4000) begin
			@(posedge clk);
			n++;
		end
		// words still owed by the sink when the limit runs out count as a failure
		if (sb.size() > 0) err_count++;
		repeat (20) @(posedge clk);
		#1 `CHK("empty", 1'b1, buffer_empty)
	endtask

	task automatic do_reset();
		sys_rst = 1;
		repeat (12) @(posedge clk);
		#1 sys_rst = 0;
		sb.delete();
		@(posedge clk);
		#1 `CHK("clear_n", 1'b0, fifo_pins.buffer_clear_n)
		repeat (30) @(posedge clk);
		#1 `CHK("empty_after_clear", 1'b1, buffer_empty)
	endtask

	task automatic print_verdict();
		if (err_count == 0 && num_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	initial begin
		seed = 32'hf32e;
		clk = 0;
		ce = 1;
		wr_valid = 0;
		rd_ready = 0;
		wr_word = '0;
		rd_on = 0;
		err_count = 0;
		num_checks = 0;
		cyc = 0;
		do_reset();
		// fill to the brim with the sink stalled
		for (int i = 0; i < DEPTH; i++) put(WORD_W'($random(seed)));
		repeat (20) @(posedge clk);
		#1 `CHK("full", 1'b1, buffer_full)
		`CHK("space_flag", 1'b0, fifo_sense.space_avail_flag)
		`CHK("wr_ready_full", 1'b0, wr_ready)
		drain();
		`CHK("last_word", last_word, fifo_sense.read_word_out)
		`CHK("oe_n", 1'b0, fifo_pins.output_enable_n)
		// clock enable low refuses writes
		ce = 0;
		repeat (3) @(posedge clk);
		#1 `CHK("wr_ready_ce", 1'b0, wr_ready)
		ce = 1;
		// streaming with random stalls, boundary words first
		put(5'h00);
		put(5'h1F);
		for (int i = 0; i < 40; i++) put(WORD_W'($random(seed)));
		drain();
		// reset in mid-run drops stored words
		rd_on = 0;
		for (int i = 0; i < 5; i++) put(WORD_W'($random(seed)));
		do_reset();
		for (int i = 0; i < 3; i++) put(WORD_W'($random(seed)));
		drain();
		print_verdict();
	end
endmodule
